// ### core/ifec_defs.vh
// Constants for the interrupt flag and enable control block
`ifndef IFEC_DEFS_VH
`define IFEC_DEFS_VH
`define IFEC_ADDR_W          4
`define IFEC_GCTL_OFS        4'h0
`define IFEC_FLAG_OFS        4'h1
`define IFEC_ENA_OFS         4'h2
`define IFEC_TIMED_IRQ_DISABLE_ACTIVE_OFS        4'h3
`define IFEC_GCTL_ALT_BIT    15
`define IFEC_GCTL_TIMED_IRQ_DISABLE_ACTIVE_BIT   14
`define IFEC_GCTL_WMASK      16'h801F
`define IFEC_FLAG_WMASK      16'hFFFB
`define IFEC_ENA_WMASK       16'hFFFB
`define IFEC_RESET_VAL       16'h0000
`define IFEC_FLAG_EXT2_BIT   13
`define IFEC_FLAG_EXT1_BIT   4
`define IFEC_IVT_BASE        24'h000014
`define IFEC_AIVT_BASE       24'h000114
`define IFEC_VEC_STEP_SHIFT  1
`define IFEC_IRQ_NUM_W       6
`define IFEC_TIMED_IRQ_DISABLE_ACTIVE_CNT_W      14
`endif

// ### core/ifec_sync.v
// Two-stage synchroniser for a bank of external pins
`timescale 1ns/100ps
`default_nettype none
module ifec_sync #(
	parameter W = 5
) (
	// Clock and reset
	input  wire         ref_clk_i,
	input  wire         rstn_i,
	// Pins and synchronised copy
	input  wire [W-1:0] pin_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// First stage is read only by the second stage
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end
		else
		begin
			meta_q <= pin_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule
`default_nettype wire

// ### core/ifec_edge.v
// Polarity-selectable edge detectors, one per external pin
`timescale 1ns/100ps
`default_nettype none
module ifec_edge #(
	parameter W = 5
) (
	// Clock and reset
	input  wire         ref_clk_i,
	input  wire         rstn_i,
	// Synchronised level and polarity select
	input  wire [W-1:0] level_i,
	input  wire [W-1:0] neg_i,
	// One-cycle edge pulses
	output wire [W-1:0] edge_o
);
	reg [W-1:0] prev_q;
	genvar g;

	// Previous level, reset low so a pin held high at release is an edge
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prev_q <= {W{1'b0}};
		else
			prev_q <= level_i;
	end

	// Per-pin edge choice
	generate
		for (g = 0; g < W; g = g + 1)
		begin : g_pin
			assign edge_o[g] = neg_i[g] ? (prev_q[g] & ~level_i[g])
				: (~prev_q[g] & level_i[g]);
		end
	endgenerate
endmodule
`default_nettype wire

// ### core/ifec_top.v
// Interrupt global control, flag status and enable registers
// Overview of operation
// - Vector table select bit 15 set picks alternate table, reset standard.
// - Read-only bit 14 shows timed interrupt disable active, resets zero.
// - Polarity bits 0-4: one means falling edge, zero rising edge.
// - Unimplemented bits read zero and ignore writes.
// - Flag high byte: uart2 tx/rx, ext2, timer5/4, compare4/3, dma2.
// - Flags read one after a request, are read-write, reset to zero.
// - Enable bits 3, 1, 0 gate pin change and i2c master/slave.
// - Vector address is table base plus two bytes per request number.
`include "ifec_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module ifec_top #(
	parameter NEXT = 5
) (
	// Clock and reset
	input  wire                       ref_clk_i,
	input  wire                       rstn_i,
	// Register port
	input  wire [`IFEC_ADDR_W-1:0]    addr_i,
	input  wire [15:0]                wdata_i,
	input  wire                       wr_i,
	input  wire                       rd_i,
	output wire [15:0]                rdata_o,
	// External interrupt pins
	input  wire [NEXT-1:0]            ext_pin_i,
	// Peripheral event pulses, flag layout (bits 13, 4, 2 unused)
	input  wire [15:0]                src_event_i,
	// Timed disable request from the core: load count
	input  wire                       timed_irq_disable_active_load_i,
	input  wire [`IFEC_TIMED_IRQ_DISABLE_ACTIVE_CNT_W-1:0] timed_irq_disable_active_cnt_i,
	// Ext pin 0-4 edge pulses; pins 0/3/4 feed other flag groups
	output wire [NEXT-1:0]            ext_edge_o,
	// Requests towards the core
	output wire [15:0]                irq_req_o,
	output wire                       irq_o,
	output wire                       alt_vector_table_select_o,
	output wire                       timed_irq_disable_active_o,
	// Vector lookup
	input  wire [`IFEC_IRQ_NUM_W-1:0] irq_num_i,
	output wire [23:0]                vec_addr_o
);
	reg  [15:0]                 gctl_q;
	reg  [15:0]                 flag_q;
	reg  [15:0]                 flag_d;
	reg  [15:0]                 ena_q;
	reg  [15:0]                 rdata_q;
	reg  [15:0]                 rdata_d;
	reg  [15:0]                 req_q;
	reg                         irq_q;
	reg  [`IFEC_TIMED_IRQ_DISABLE_ACTIVE_CNT_W-1:0] timed_irq_disable_active_q;
	reg                         timed_irq_disable_active_act_q;
	reg  [NEXT-1:0]             edge_q;
	reg  [23:0]                 vec_q;
	wire [NEXT-1:0]             ext_sync;
	wire [NEXT-1:0]             ext_edge;
	wire [15:0]                 set_vec;
	wire [23:0]                 vec_base;
	wire [23:0]                 vec_off;
	reg  [15:0]                 gctl_d;
	reg  [15:0]                 ena_d;
	// Named fields of the global control register
	wire                        alt_vector_table_select;
	wire                        timed_irq_disable_active;
	wire                        ext_irq0_edge_polarity;
	wire                        ext_irq1_edge_polarity;
	wire                        ext_irq2_edge_polarity;
	wire                        ext_irq3_edge_polarity;
	wire                        ext_irq4_edge_polarity;
	// Named flag bits in register order
	wire                        uart2_tx_flag;
	wire                        uart2_rx_flag;
	wire                        ext_irq2_flag;
	wire                        timer5_flag;
	wire                        timer4_flag;
	wire                        compare4_flag;
	wire                        compare3_flag;
	wire                        dma_ch2_done_flag;
	wire                        capture8_flag;
	wire                        capture7_flag;
	wire                        adc2_done_flag;
	wire                        ext_irq1_flag;
	wire                        pin_change_flag;
	wire                        i2c_master_event_flag;
	wire                        i2c_slave_event_flag;
	// Named enable bits that gate the low sources
	wire                        pin_change_enable;
	wire                        i2c_master_event_enable;
	wire                        i2c_slave_event_enable;
	// Read-back images with reserved bits forced low
	wire [15:0]                 gctl_img;
	wire [15:0]                 flag_img;
	wire [15:0]                 ena_img;

	// Pins cross into the clock domain first
	ifec_sync #(.W(NEXT)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.pin_i     (ext_pin_i),
		.sync_o    (ext_sync)
	);

	// Edge choice per pin follows its polarity bit
	ifec_edge #(.W(NEXT)) u_edge (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.level_i   (ext_sync),
		.neg_i     (gctl_q[NEXT-1:0]),
		.edge_o    (ext_edge)
	);

	// Event sources per flag bit; ext pins 1 and 2 land in this group
	assign set_vec = (src_event_i & `IFEC_FLAG_WMASK
		& ~(16'h0001 << `IFEC_FLAG_EXT2_BIT)
		& ~(16'h0001 << `IFEC_FLAG_EXT1_BIT))
		| ({15'h0000, ext_edge[2]} << `IFEC_FLAG_EXT2_BIT)
		| ({15'h0000, ext_edge[1]} << `IFEC_FLAG_EXT1_BIT);

	// Control next value; bit 14 and bits 13..5 never store a write
	always @*
	begin
		gctl_d = gctl_q;
		if (wr_i && addr_i == `IFEC_GCTL_OFS)
			gctl_d = wdata_i & `IFEC_GCTL_WMASK;
	end

	// Global control register, only select and polarity bits are writable
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			gctl_q <= `IFEC_RESET_VAL;
		else
			gctl_q <= gctl_d;
	end

	// Control fields; disable status comes from the counter, not a write
	assign alt_vector_table_select  = gctl_q[`IFEC_GCTL_ALT_BIT];
	assign timed_irq_disable_active = timed_irq_disable_active_act_q;
	assign ext_irq0_edge_polarity   = gctl_q[0];
	assign ext_irq1_edge_polarity   = gctl_q[1];
	assign ext_irq2_edge_polarity   = gctl_q[2];
	assign ext_irq3_edge_polarity   = gctl_q[3];
	assign ext_irq4_edge_polarity   = gctl_q[4];
	assign gctl_img = {alt_vector_table_select, timed_irq_disable_active,
		9'h000, ext_irq4_edge_polarity, ext_irq3_edge_polarity,
		ext_irq2_edge_polarity, ext_irq1_edge_polarity,
		ext_irq0_edge_polarity};

	// Flag next value: software write, then hardware set wins
	always @*
	begin
		flag_d = flag_q;
		if (wr_i && addr_i == `IFEC_FLAG_OFS)
			flag_d = wdata_i & `IFEC_FLAG_WMASK;
		flag_d = flag_d | set_vec;
	end

	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			flag_q <= `IFEC_RESET_VAL;
		else
			flag_q <= flag_d;
	end

	// Enable next value; bit 2 is not implemented
	always @*
	begin
		ena_d = ena_q;
		if (wr_i && addr_i == `IFEC_ENA_OFS)
			ena_d = wdata_i & `IFEC_ENA_WMASK;
	end

	// Enable register
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ena_q <= `IFEC_RESET_VAL;
		else
			ena_q <= ena_d;
	end

	// Enable fields; upper bits gate the other sources of this group
	assign pin_change_enable       = ena_q[3];
	assign i2c_master_event_enable = ena_q[1];
	assign i2c_slave_event_enable  = ena_q[0];
	assign ena_img = {ena_q[15:4], pin_change_enable, 1'b0,
		i2c_master_event_enable, i2c_slave_event_enable};

	// Flag fields by source, high byte then low byte
	assign uart2_tx_flag         = flag_q[15];
	assign uart2_rx_flag         = flag_q[14];
	assign ext_irq2_flag         = flag_q[`IFEC_FLAG_EXT2_BIT];
	assign timer5_flag           = flag_q[12];
	assign timer4_flag           = flag_q[11];
	assign compare4_flag         = flag_q[10];
	assign compare3_flag         = flag_q[9];
	assign dma_ch2_done_flag     = flag_q[8];
	assign capture8_flag         = flag_q[7];
	assign capture7_flag         = flag_q[6];
	assign adc2_done_flag        = flag_q[5];
	assign ext_irq1_flag         = flag_q[`IFEC_FLAG_EXT1_BIT];
	assign pin_change_flag       = flag_q[3];
	assign i2c_master_event_flag = flag_q[1];
	assign i2c_slave_event_flag  = flag_q[0];
	assign flag_img = {uart2_tx_flag, uart2_rx_flag, ext_irq2_flag,
		timer5_flag, timer4_flag, compare4_flag, compare3_flag,
		dma_ch2_done_flag, capture8_flag, capture7_flag, adc2_done_flag,
		ext_irq1_flag, pin_change_flag, 1'b0, i2c_master_event_flag,
		i2c_slave_event_flag};

	// Timed disable counter: counts cycles, not instructions
	// A zero load ends the window at once
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			timed_irq_disable_active_q     <= {`IFEC_TIMED_IRQ_DISABLE_ACTIVE_CNT_W{1'b0}};
			timed_irq_disable_active_act_q <= 1'b0;
		end
		else if (timed_irq_disable_active_load_i)
		begin
			timed_irq_disable_active_q     <= timed_irq_disable_active_cnt_i;
			timed_irq_disable_active_act_q <= (timed_irq_disable_active_cnt_i != {`IFEC_TIMED_IRQ_DISABLE_ACTIVE_CNT_W{1'b0}});
		end
		else if (timed_irq_disable_active_act_q)
		begin
			timed_irq_disable_active_q     <= timed_irq_disable_active_q - 1'b1;
			timed_irq_disable_active_act_q <= (timed_irq_disable_active_q != {{(`IFEC_TIMED_IRQ_DISABLE_ACTIVE_CNT_W-1){1'b0}}, 1'b1});
		end
	end

	// Forwarded requests; the core applies the disable window itself
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			req_q  <= 16'h0000;
			irq_q  <= 1'b0;
			edge_q <= {NEXT{1'b0}};
		end
		else
		begin
			req_q  <= flag_d & ena_q;
			irq_q  <= |(flag_d & ena_q);
			edge_q <= ext_edge;
		end
	end

	// Vector base chosen by table select, two bytes per request
	assign vec_base = gctl_q[`IFEC_GCTL_ALT_BIT] ? `IFEC_AIVT_BASE
		: `IFEC_IVT_BASE;
	assign vec_off = {{(24-`IFEC_IRQ_NUM_W){1'b0}}, irq_num_i}
		<< `IFEC_VEC_STEP_SHIFT;

	// Registered so the core always sees a settled address
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			vec_q <= `IFEC_IVT_BASE;
		else
			vec_q <= vec_base + vec_off;
	end

	// Read mux; unmapped addresses and reserved bits return zero
	always @*
	begin
		rdata_d = 16'h0000;
		case (addr_i)
			`IFEC_GCTL_OFS: rdata_d = gctl_img;
			`IFEC_FLAG_OFS: rdata_d = flag_img;
			`IFEC_ENA_OFS:  rdata_d = ena_img;
			`IFEC_TIMED_IRQ_DISABLE_ACTIVE_OFS:
				rdata_d = {{(16-`IFEC_TIMED_IRQ_DISABLE_ACTIVE_CNT_W){1'b0}}, timed_irq_disable_active_q};
			default:        rdata_d = 16'h0000;
		endcase
	end

	// Data stands one cycle after the strobe only
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_q <= 16'h0000;
		else if (rd_i)
			rdata_q <= rdata_d;
		else
			rdata_q <= 16'h0000;
	end

	// Registered outputs only
	assign rdata_o                    = rdata_q;
	assign irq_req_o                  = req_q;
	assign irq_o                      = irq_q;
	assign alt_vector_table_select_o  = alt_vector_table_select;
	assign timed_irq_disable_active_o = timed_irq_disable_active;
	assign ext_edge_o                 = edge_q;
	assign vec_addr_o                 = vec_q;
endmodule
`default_nettype wire

// ### test/ifec_checker.sv
// Port assertions for the interrupt flag and enable block
`timescale 1ns/100ps
`default_nettype none
module ifec_checker #(
	parameter NEXT = 5
) (
	// Clock and reset
	input wire logic             ref_clk_i,
	input wire logic             rstn_i,
	// Register port
	input wire logic [3:0]       addr_i,
	input wire logic [15:0]      wdata_i,
	input wire logic             wr_i,
	input wire logic             rd_i,
	input wire logic [15:0]      rdata_o,
	// Timed disable
	input wire logic             timed_irq_disable_active_load_i,
	input wire logic [13:0]      timed_irq_disable_active_cnt_i,
	input wire logic             timed_irq_disable_active_o,
	// Requests, edges and vectors
	input wire logic [15:0]      irq_req_o,
	input wire logic             irq_o,
	input wire logic [NEXT-1:0]  ext_edge_o,
	input wire logic             alt_vector_table_select_o,
	input wire logic [5:0]       irq_num_i,
	input wire logic [23:0]      vec_addr_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	// Table select follows a write within two cycles
	property p_alt; wr_i && addr_i == 4'h0 && wdata_i[15] |->
		##[1:2] alt_vector_table_select_o; endproperty
	a_alt: assert property (p_alt) else $error("alt");
	// Settled vector is base plus two bytes per request
	property p_vec; ($stable(irq_num_i) &&
		$stable(alt_vector_table_select_o)) [*2] |->
		vec_addr_o == {17'h0, irq_num_i, 1'h0} +
		(alt_vector_table_select_o ? 24'h000114 : 24'h000014); endproperty
	a_vec: assert property (p_vec) else $error("vec");
	// Summary line is exactly the OR of the requests
	property p_irq; irq_o == (irq_req_o != 16'h0000); endproperty
	a_irq: assert property (p_irq) else $error("irq");
	// Enable writes act a cycle late, so two quiet cycles are needed
	property p_stk; !wr_i && !$past(wr_i) |=>
		(irq_req_o & $past(irq_req_o)) == $past(irq_req_o); endproperty
	a_stk: assert property (p_stk) else $error("sticky");
	// Edge pulses last one cycle
	property p_edg; ext_edge_o != '0 |=>
		(ext_edge_o & $past(ext_edge_o)) == '0; endproperty
	a_edg: assert property (p_edg) else $error("edge");
	// A four-cycle disable is over after eight quiet cycles
	property p_dof; timed_irq_disable_active_load_i && timed_irq_disable_active_cnt_i == 14'h0004 ##1
		!timed_irq_disable_active_load_i [*8] |-> !timed_irq_disable_active_o; endproperty
	a_dof: assert property (p_dof) else $error("disable");
	// Unused control bits read zero
	property p_rg; rd_i && addr_i == 4'h0 |=>
		rdata_o[13:5] == 9'h000; endproperty
	a_rg: assert property (p_rg) else $error("gctl");
	property p_rb; rd_i && (addr_i == 4'h1 || addr_i == 4'h2) |=>
		rdata_o[2] == 1'h0; endproperty
	a_rb: assert property (p_rb) else $error("bit2");
endmodule
bind ifec_top ifec_checker #(.NEXT(NEXT)) i_ifec_checker (.*);
`default_nettype wire

// ### test/ifec_peer.sv
// Model of the event sources, pins and core beside the block
`timescale 1ns/100ps
`default_nettype none
module ifec_peer (
	// Clock
	input  wire logic        ref_clk_i,
	// Events, pins and timed disable load
	output var  logic [15:0] ev_o,
	output var  logic [4:0]  pin_o,
	output var  logic        ld_o,
	output var  logic [13:0] cnt_o
);
	// Quiet at time zero
	initial
	begin
		{ev_o, pin_o, ld_o, cnt_o} = '0;
	end
	// One-cycle burst of events
	task automatic fire(input logic [15:0] e);
		@(posedge ref_clk_i) ev_o <= e;
		@(posedge ref_clk_i) ev_o <= 16'h0000;
	endtask
	// Pins move just after an edge
	task automatic pins(input logic [4:0] v);
		@(posedge ref_clk_i) pin_o <= v;
	endtask
	// Count is only meaningful beside the load
	task automatic dis(input logic [13:0] n);
		@(posedge ref_clk_i) {ld_o, cnt_o} <= {1'h1, n};
		@(posedge ref_clk_i) {ld_o, cnt_o} <= {1'h0, ~n};
	endtask
endmodule
`default_nettype wire

// ### test/ifec_top_tb.sv
// Self-checking bench for the interrupt flag and enable block
`timescale 1ns/100ps
`default_nettype none
module ifec_top_tb;
	logic        clk, rstn, wr, rd, ld, irq, alt, dis;
	logic [3:0]  adr;
	logic [4:0]  pin, edg;
	logic [5:0]  num;
	logic [13:0] cnt;
	logic [15:0] wd, rdat, ev, req;
	logic [23:0] vec;
	int          err_total, total_checks;
	// Block and its far side
	ifec_top i_ifec_top (.ref_clk_i(clk), .rstn_i(rstn), .addr_i(adr),
		.wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
		.ext_pin_i(pin), .src_event_i(ev), .timed_irq_disable_active_load_i(ld),
		.timed_irq_disable_active_cnt_i(cnt), .ext_edge_o(edg), .irq_req_o(req), .irq_o(irq),
		.alt_vector_table_select_o(alt),
		.timed_irq_disable_active_o(dis), .irq_num_i(num),
		.vec_addr_o(vec));
	ifec_peer i_ifec_peer (.ref_clk_i(clk), .ev_o(ev), .pin_o(pin),
		.ld_o(ld), .cnt_o(cnt));
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic bw(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk) {wr, adr, wd} <= {1'h1, a, d};
		@(posedge clk) wr <= 1'h0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic br(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk) {rd, adr} <= {1'h1, a};
		@(posedge clk) rd <= 1'h0;
		#1 chk(rdat, e);
	endtask
	task automatic t_reg;
		@(posedge clk) num <= 6'h1F;
		bw(4'h0, 16'hFFFF);
		br(4'h0, 16'h801F);
		chk(alt, 24'h000001);
		chk(vec, 24'h000152);
		bw(4'h2, 16'hFFFF);
		br(4'h2, 16'hFFFB);
		bw(4'h1, 16'hFFFF);
		br(4'h1, 16'hFFFB);
		chk({req, 7'h00, irq}, {16'hFFFB, 8'h01});
		bw(4'h1, 16'h0000);
		br(4'h1, 16'h0000);
		br(4'h7, 16'h0000);
		$display("t_reg done");
	endtask
	// Unused event bits must not reach the flags
	task automatic t_evt;
		bw(4'h2, 16'h000B);
		i_ifec_peer.fire(16'hFFFF);
		#1 chk({req, 7'h00, irq}, {16'h000B, 8'h01});
		bw(4'h2, 16'h0000);
		br(4'h1, 16'hDFEB);
		chk({req, 7'h00, irq}, 24'h000000);
		bw(4'h1, 16'h0000);
		$display("t_evt done");
	endtask
	// Pin 2 falling, the rest rising
	task automatic t_pin;
		bw(4'h0, 16'h0004);
		i_ifec_peer.pins(5'h1F);
		repeat (3) @(posedge clk);
		#1 chk(edg, 24'h00001B);
		br(4'h1, 16'h0010);
		i_ifec_peer.pins(5'h00);
		repeat (3) @(posedge clk);
		#1 chk(edg, 24'h000004);
		br(4'h1, 16'h2010);
		chk(vec, 24'h000052);
		bw(4'h1, 16'h0000);
		bw(4'h0, 16'h0000);
		$display("t_pin done");
	endtask
	task automatic t_dis;
		i_ifec_peer.dis(14'h0004);
		br(4'h0, 16'h4000);
		chk(dis, 24'h000001);
		br(4'h3, 16'h0001);
		bw(4'h3, 16'hFFFF);
		repeat (8) @(posedge clk);
		br(4'h0, 16'h0000);
		chk(dis, 24'h000000);
		br(4'h3, 16'h0000);
		$display("t_dis done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Reset two cycles, then the scenarios
	initial
	begin
		{rstn, wr, rd, adr, wd, num} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		br(4'h0, 16'h0000);
		br(4'h1, 16'h0000);
		chk(vec, 24'h000014);
		t_reg;
		t_evt;
		t_pin;
		t_dis;
		report_and_stop;
	end
	// Hang guard
	initial
	begin
		repeat (3000) @(posedge clk);
		err_total++;
		report_and_stop;
	end
endmodule
`default_nettype wire
